// ===== design/zlac_top.sv
// zone lock access control: lock bytes, otp zone modes and axi4-lite registers
//
// Summary of operation
// - identification bytes 0..12 are never writable and always readable.
// - the three fixed id bytes always enter every hash input.
// - the six per-die id bytes enter a hash only when selected.
// - revision bytes read freely; software should not rely on values.
// - otp zone is 64 bytes, sixteen 32-bit words from word zero.
// - with configuration unlocked, all otp reads and writes are refused.
// - configuration locked, otp unlocked: writes accepted, reads refused.
// - read-only mode: writes error and change nothing; 4 and 32-byte reads served.
// - consumption mode stores data anded with the existing word.
// - legacy mode refuses reads of words zero and one, allows others.
// - legacy mode: only 4-byte reads, 32-byte read errors, writes refused.
// - every otp bit starts at one.
// - byte 87 locks configuration; byte 86 locks data and otp together.
// - lock bytes change only by the lock command; no unlock command exists, but reset reloads both at 0x55.
// - data/otp lock enables slot policies; slots stay writable per policy.
// - data or otp access with configuration unlocked answers an error.
// - configuration unlocked only at 0x55; otherwise reads only.
// - data/otp lock at 0x55 allows writes only; otherwise slot policy.
// - configuration lock value 0x00 means writes to configuration withdrawn.
`timescale 1ns/1ps
`include "zlac_defs.svh"
module zlac_top
  import zlac_pkg::*;
#(
  parameter logic [23:0] FIXED_ID = 24'h5a5a5a, // arbitrary value
  parameter logic [47:0] DIE_ID = 48'h3a7c915e26d4, // arbitrary value
  parameter logic [31:0] REVISION = 32'h00000001, // arbitrary value
  parameter int OTP_WORDS = 16
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [11:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic SLOT_POLICY_EN_OUT
);

  if (OTP_WORDS != 16) begin : g_bad_otp_words
    $error("otp zone holds exactly sixteen words");
  end

  zlac_state_t s_r;
  zlac_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // access decisions

  function automatic logic is_unlocked(input logic [7:0] v);
    return v == `ZLAC_UNLOCKED;
  endfunction

  logic cfg_open;
  logic dat_open;
  zlac_mode_t mode;
  assign cfg_open = is_unlocked(s_r.config_zone_lock);
  assign dat_open = is_unlocked(s_r.data_otp_lock);
  assign SLOT_POLICY_EN_OUT = !dat_open;

  always_comb begin
    unique case (s_r.otp_mode)
      2'h1: mode = ZLAC_MODE_CONSUME;
      2'h2: mode = ZLAC_MODE_LEGACY;
      default: mode = ZLAC_MODE_READ_ONLY; // any other code reads only
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic wr_go;
  logic rd_go;
  logic [11:0] waddr;
  logic [31:0] wval;
  assign S_AXI_AWREADY_OUT = !s_r.aw_held && !s_r.bvalid;
  assign S_AXI_WREADY_OUT = !s_r.w_held && !s_r.bvalid;
  assign S_AXI_ARREADY_OUT = !s_r.rvalid;
  assign waddr = s_r.aw_held ? s_r.awaddr : S_AXI_AWADDR_IN;
  assign wval = s_r.w_held ? s_r.wdata : S_AXI_WDATA_IN;
  assign wr_go = (s_r.aw_held || (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT))
              && (s_r.w_held || (S_AXI_WVALID_IN && S_AXI_WREADY_OUT));
  assign rd_go = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign S_AXI_BVALID_OUT = s_r.bvalid;
  assign S_AXI_BRESP_OUT = s_r.bresp;
  assign S_AXI_RVALID_OUT = s_r.rvalid;
  assign S_AXI_RDATA_OUT = s_r.rdata;
  assign S_AXI_RRESP_OUT = s_r.rresp;

  ////////////////////////////////////////////////////////////////////////
  // command execution

  zlac_cmd_t cmd;
  logic [3:0] word;
  logic [31:0] cur_word;
  logic [31:0] next_word;
  logic ok;
  logic do_write;
  assign cmd = zlac_cmd_t'(wval[11:0]);
  assign word = cmd.addr[5:2];
  assign cur_word = s_r.otp[word*32 +: 32];

  always_comb begin
    ok = 1'b0;
    do_write = 1'b0;
    next_word = s_r.wdata_buf;
    unique case (cmd.zone)
      ZLAC_ZONE_CONFIG: begin
        if (cmd.op == ZLAC_OP_WRITE) begin
          ok = cfg_open && cmd.addr > `ZLAC_FIXED_INFO_LAST;
        end else if (cmd.op != ZLAC_OP_LOCK) begin
          ok = 1'b1;
        end else begin
          ok = cfg_open;
        end
      end
      ZLAC_ZONE_DATA: begin
        if (cmd.op == ZLAC_OP_LOCK) begin
          ok = !cfg_open && dat_open;
        end else if (cmd.op == ZLAC_OP_WRITE) begin
          ok = !cfg_open; // slot policy handled outside
        end else begin
          ok = !cfg_open && !dat_open;
        end
      end
      ZLAC_ZONE_OTP: begin
        if (cfg_open) begin
          ok = 1'b0;
        end else if (dat_open) begin
          ok = cmd.op == ZLAC_OP_WRITE;
          do_write = ok;
        end else begin
          unique case (mode)
            ZLAC_MODE_READ_ONLY: ok = cmd.op == ZLAC_OP_READ4 || cmd.op == ZLAC_OP_READ32;
            ZLAC_MODE_CONSUME: begin
              ok = cmd.op != ZLAC_OP_LOCK;
              do_write = cmd.op == ZLAC_OP_WRITE;
              next_word = cur_word & s_r.wdata_buf;
            end
            ZLAC_MODE_LEGACY: ok = cmd.op == ZLAC_OP_READ4 && word > 4'h1;
          endcase
        end
      end
      default: ok = 1'b0;
    endcase
  end

  function automatic logic [31:0] reg_read(input zlac_state_t s, input logic [11:0] a, input logic [31:0] id_hash);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      `ZLAC_OFF_RDATA: r = s.rdata_buf;
      `ZLAC_OFF_STATUS: r = {30'h0, s.cmd_err, s.cmd_done};
      `ZLAC_OFF_OTP_MODE: r = {30'h0, s.otp_mode};
      `ZLAC_OFF_DIGEST_SEL: r = {30'h0, s.digest_sel};
      `ZLAC_OFF_ID_LO: r = {FIXED_ID[15:0], DIE_ID[47:32]};
      `ZLAC_OFF_ID_HI: r = DIE_ID[31:0];
      `ZLAC_OFF_REV: r = REVISION;
      `ZLAC_OFF_HASH_PREFIX: r = id_hash;
      `ZLAC_OFF_DATA_OTP_LOCK: r = {24'h0, s.data_otp_lock};
      `ZLAC_OFF_CONFIG_ZONE_LOCK: r = {24'h0, s.config_zone_lock};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // hash prefix: fixed id always, per-die bytes only when selected
  logic [31:0] hash_prefix;
  always_comb begin
    hash_prefix = {FIXED_ID, 8'h0};
    if (s_r.digest_sel[0]) begin
      hash_prefix = {FIXED_ID, DIE_ID[7:0] ^ DIE_ID[15:8] ^ DIE_ID[23:16]
                     ^ DIE_ID[31:24] ^ DIE_ID[39:32] ^ DIE_ID[47:40]};
    end
  end

  logic known_addr;
  always_comb begin
    known_addr = 1'b1;
    unique case (S_AXI_ARADDR_IN)
      `ZLAC_OFF_RDATA, `ZLAC_OFF_STATUS, `ZLAC_OFF_OTP_MODE, `ZLAC_OFF_DIGEST_SEL,
      `ZLAC_OFF_ID_LO, `ZLAC_OFF_ID_HI, `ZLAC_OFF_REV, `ZLAC_OFF_HASH_PREFIX,
      `ZLAC_OFF_DATA_OTP_LOCK, `ZLAC_OFF_CONFIG_ZONE_LOCK, `ZLAC_OFF_WDATA: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = S_AXI_WDATA_IN;
    end
    if (s_r.bvalid && S_AXI_BREADY_IN) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && S_AXI_RREADY_IN) begin
      s_nxt.rvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `ZLAC_RESP_OKAY;
      unique case (waddr)
        `ZLAC_OFF_WDATA: s_nxt.wdata_buf = wval;
        `ZLAC_OFF_OTP_MODE: begin
          if (cfg_open) begin
            s_nxt.otp_mode = wval[1:0];
          end
        end
        `ZLAC_OFF_DIGEST_SEL: s_nxt.digest_sel = wval[1:0];
        `ZLAC_OFF_CMD: begin
          if (wval[`ZLAC_CMD_GO_BIT]) begin
            s_nxt.cmd_done = 1'b1;
            s_nxt.cmd_err = !ok;
            if (ok && cmd.op == ZLAC_OP_LOCK) begin
              if (cmd.zone == ZLAC_ZONE_CONFIG) begin
                s_nxt.config_zone_lock = `ZLAC_LOCKED;
              end else begin
                s_nxt.data_otp_lock = `ZLAC_LOCKED;
              end
            end
            if (ok && cmd.zone == ZLAC_ZONE_OTP && (cmd.op == ZLAC_OP_READ4 || cmd.op == ZLAC_OP_READ32)) begin
              s_nxt.rdata_buf = cur_word; // 32-byte read returns the first word here
            end
            if (ok && do_write) begin
              s_nxt.otp[word*32 +: 32] = next_word;
            end
          end
        end
        // lock bytes are read-only over the bus: only the lock command moves them
        `ZLAC_OFF_DATA_OTP_LOCK, `ZLAC_OFF_CONFIG_ZONE_LOCK: s_nxt.bresp = `ZLAC_RESP_SLVERR;
        default: s_nxt.bresp = `ZLAC_RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = reg_read(s_r, S_AXI_ARADDR_IN, hash_prefix);
      s_nxt.rresp = known_addr ? `ZLAC_RESP_OKAY : `ZLAC_RESP_SLVERR;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_r <= '0;
      s_r.config_zone_lock <= `ZLAC_UNLOCKED;
      s_r.data_otp_lock <= `ZLAC_UNLOCKED;
      s_r.otp <= {16{`ZLAC_OTP_ERASED}};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_lock_sticky;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !cfg_open |=> !cfg_open;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("config lock reopened");

  property p_data_sticky;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !dat_open |=> !dat_open;
  endproperty
  a_data_sticky: assert property (p_data_sticky) else $error("data lock reopened");

  property p_otp_closed;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (wr_go && waddr == `ZLAC_OFF_CMD && wval[31] && cmd.zone == ZLAC_ZONE_OTP && cfg_open) |=> s_r.cmd_err;
  endproperty
  a_otp_closed: assert property (p_otp_closed) else $error("otp access with config open");

  property p_ro_nowrite;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!dat_open && mode == ZLAC_MODE_READ_ONLY) |=> $stable(s_r.otp);
  endproperty
  a_ro_nowrite: assert property (p_ro_nowrite) else $error("read-only otp changed");

  property p_consume;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !dat_open |=> ((s_r.otp & ~$past(s_r.otp)) == '0);
  endproperty
  a_consume: assert property (p_consume) else $error("otp bit returned to one");

  property p_legacy_low;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (wr_go && waddr == `ZLAC_OFF_CMD && wval[31] && cmd.zone == ZLAC_ZONE_OTP && !cfg_open && !dat_open
     && mode == ZLAC_MODE_LEGACY && word < 4'h2) |=> s_r.cmd_err;
  endproperty
  a_legacy_low: assert property (p_legacy_low) else $error("legacy word 0/1 read allowed");

  property p_fixed;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (wr_go && waddr == `ZLAC_OFF_CMD && wval[31] && cmd.zone == ZLAC_ZONE_CONFIG
     && cmd.op == ZLAC_OP_WRITE && cmd.addr <= 8'h0c) |=> s_r.cmd_err;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bytes written");

  property p_policy;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    SLOT_POLICY_EN_OUT |-> !cfg_open;
  endproperty
  a_policy: assert property (p_policy) else $error("slot policy enabled with config open");

  property p_cfg_locked_write;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (wr_go && waddr == `ZLAC_OFF_CMD && wval[`ZLAC_CMD_GO_BIT] && cmd.zone == ZLAC_ZONE_CONFIG
     && cmd.op == ZLAC_OP_WRITE && !cfg_open) |=> s_r.cmd_err;
  endproperty
  a_cfg_locked_write: assert property (p_cfg_locked_write) else $error("config written while locked");

  property p_otp_read_open;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (wr_go && waddr == `ZLAC_OFF_CMD && wval[`ZLAC_CMD_GO_BIT] && cmd.zone == ZLAC_ZONE_OTP
     && cmd.op != ZLAC_OP_WRITE && !cfg_open && dat_open) |=> s_r.cmd_err;
  endproperty
  a_otp_read_open: assert property (p_otp_read_open) else $error("otp read before data lock");

  property p_lock_cmd_only;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !(wr_go && waddr == `ZLAC_OFF_CMD) |=> $stable(s_r.config_zone_lock) && $stable(s_r.data_otp_lock);
  endproperty
  a_lock_cmd_only: assert property (p_lock_cmd_only) else $error("lock byte changed without command");

endmodule

// ===== design/zlac_defs.svh
// offsets, field positions, reset values and codes for the zone lock access control block
`ifndef ZLAC_DEFS_SVH
`define ZLAC_DEFS_SVH
`define ZLAC_OFF_CMD 12'h000
`define ZLAC_OFF_WDATA 12'h004
`define ZLAC_OFF_RDATA 12'h008
`define ZLAC_OFF_STATUS 12'h00c
`define ZLAC_OFF_OTP_MODE 12'h010
`define ZLAC_OFF_DIGEST_SEL 12'h014
`define ZLAC_OFF_ID_LO 12'h018
`define ZLAC_OFF_ID_HI 12'h01c
`define ZLAC_OFF_REV 12'h020
`define ZLAC_OFF_HASH_PREFIX 12'h024
// lock bytes sit at word indices; byte address is four times the index
`define ZLAC_IDX_DATA_OTP_LOCK 12'h056
`define ZLAC_IDX_CONFIG_ZONE_LOCK 12'h057
`define ZLAC_OFF_DATA_OTP_LOCK (`ZLAC_IDX_DATA_OTP_LOCK << 2)
`define ZLAC_OFF_CONFIG_ZONE_LOCK (`ZLAC_IDX_CONFIG_ZONE_LOCK << 2)
`define ZLAC_UNLOCKED 8'h55
`define ZLAC_LOCKED 8'h00
`define ZLAC_OTP_ERASED 32'hffffffff
`define ZLAC_FIXED_INFO_LAST 8'h0c
`define ZLAC_CMD_GO_BIT 31
`define ZLAC_RESP_OKAY 2'b00
`define ZLAC_RESP_SLVERR 2'b10
`endif

// ===== design/zlac_pkg.sv
// types for the zone lock access control block
package zlac_pkg;
  typedef enum logic [1:0] {
    ZLAC_OP_READ4,
    ZLAC_OP_READ32,
    ZLAC_OP_WRITE,
    ZLAC_OP_LOCK
  } zlac_op_t;
  typedef enum logic [1:0] {
    ZLAC_ZONE_CONFIG,
    ZLAC_ZONE_DATA,
    ZLAC_ZONE_OTP
  } zlac_zone_t;
  typedef enum logic [1:0] {
    ZLAC_MODE_READ_ONLY,
    ZLAC_MODE_CONSUME,
    ZLAC_MODE_LEGACY
  } zlac_mode_t;
  typedef struct packed {
    zlac_op_t op;
    zlac_zone_t zone;
    logic [7:0] addr;
  } zlac_cmd_t;
  typedef struct packed {
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] config_zone_lock;
    logic [7:0] data_otp_lock;
    logic [1:0] otp_mode;
    logic [31:0] wdata_buf;
    logic [31:0] rdata_buf;
    logic cmd_done;
    logic cmd_err;
    logic [1:0] digest_sel;
    logic [511:0] otp;
  } zlac_state_t;
endpackage

// ===== sim/zlac_host.sv
// axi4-lite master standing in for the host that issues zone commands
`timescale 1ns/1ps
module zlac_host (
  input wire logic clk_in,
  output logic [11:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [11:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hf;
  end
  ////////////////////////////////////////////////////////////////
  // aw and w may be taken at different edges; each drops by itself
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (awready_in) ad = 1'b1;
      if (wready_in) wd = 1'b1;
      if (ad) awvalid_out <= 1'b0;
      if (wd) wvalid_out <= 1'b0;
    end
    do @(posedge clk_in); while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    do @(posedge clk_in); while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// ===== sim/zone_lock_access_control_test.sv
// self-checking bench for lock bytes and otp zone modes
`timescale 1ns/1ps
`include "zlac_defs.svh"
module zone_lock_access_control_test import zlac_pkg::*;;
  localparam logic [23:0] FID = 24'h3c3c3c; // arbitrary value
  localparam logic [47:0] DID = 48'ha1b2c3d4e5f6; // arbitrary value
  localparam logic [31:0] REV = 32'h00000002; // arbitrary value
  localparam logic [7:0] FOLD = DID[47:40] ^ DID[39:32] ^ DID[31:24] ^ DID[23:16] ^ DID[15:8] ^ DID[7:0];
  localparam logic [31:0] VA = 32'hf0f0a5c3;
  localparam logic [31:0] VB = 32'h3c0fff5a;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, slot_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  zlac_top #(.FIXED_ID(FID), .DIE_ID(DID), .REVISION(REV), .OTP_WORDS(16)) i_dut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .SLOT_POLICY_EN_OUT(slot_en));
  zlac_host i_host (
    .clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
    .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
    .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "read response");
    chk(d, ed, "read data");
  endtask
  // status is read back right after each command: done set, err as expected
  task automatic cmd(input zlac_op_t op, input zlac_zone_t zn, input logic [7:0] ad, input logic e);
    reg_wr(`ZLAC_OFF_CMD, {1'b1, 19'h0, op, zn, ad}, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_STATUS, {30'h0, e, 1'b1}, `ZLAC_RESP_OKAY);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    reg_rd(`ZLAC_OFF_CONFIG_ZONE_LOCK, {24'h0, `ZLAC_UNLOCKED}, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_DATA_OTP_LOCK, {24'h0, `ZLAC_UNLOCKED}, `ZLAC_RESP_OKAY);
    chk({31'h0, slot_en}, 32'h0, "slot policy off while unlocked");
    reg_rd(12'h0fc, 32'h0, `ZLAC_RESP_SLVERR);
    reg_wr(`ZLAC_OFF_CONFIG_ZONE_LOCK, 32'h0, `ZLAC_RESP_SLVERR);
    reg_rd(`ZLAC_OFF_CONFIG_ZONE_LOCK, {24'h0, `ZLAC_UNLOCKED}, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_REV, REV, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_ID_LO, {FID[15:0], DID[47:32]}, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_ID_HI, DID[31:0], `ZLAC_RESP_OKAY);
  endtask
  task automatic t_unlocked;
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h00, 1'b1);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h3c, 1'b1);
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_DATA, 8'h00, 1'b1);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_CONFIG, `ZLAC_FIXED_INFO_LAST, 1'b1);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_CONFIG, 8'h10, 1'b0);
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_CONFIG, 8'h00, 1'b0);
    cmd(ZLAC_OP_LOCK, ZLAC_ZONE_DATA, 8'h00, 1'b1);
    reg_wr(`ZLAC_OFF_DIGEST_SEL, 32'h0, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_HASH_PREFIX, {FID, 8'h00}, `ZLAC_RESP_OKAY);
    reg_wr(`ZLAC_OFF_DIGEST_SEL, 32'h1, `ZLAC_RESP_OKAY);
    reg_rd(`ZLAC_OFF_HASH_PREFIX, {FID, FOLD}, `ZLAC_RESP_OKAY);
  endtask
  // fixed personalisation order: config, config lock, otp data, data lock
  task automatic t_mode(input logic [1:0] m);
    do_reset;
    reg_wr(`ZLAC_OFF_OTP_MODE, {30'h0, m}, `ZLAC_RESP_OKAY);
    cmd(ZLAC_OP_LOCK, ZLAC_ZONE_CONFIG, 8'h00, 1'b0);
    reg_rd(`ZLAC_OFF_CONFIG_ZONE_LOCK, {24'h0, `ZLAC_LOCKED}, `ZLAC_RESP_OKAY);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_CONFIG, 8'h10, 1'b1);
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_DATA, 8'h00, 1'b1);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_DATA, 8'h00, 1'b0);
    reg_wr(`ZLAC_OFF_WDATA, VA, `ZLAC_RESP_OKAY);
    cmd(ZLAC_OP_WRITE, zlac_zone_t'(2'h3), 8'h0c, 1'b1);
    cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h0c, 1'b1);
    cmd(ZLAC_OP_LOCK, ZLAC_ZONE_DATA, 8'h00, 1'b0);
    reg_rd(`ZLAC_OFF_DATA_OTP_LOCK, {24'h0, `ZLAC_LOCKED}, `ZLAC_RESP_OKAY);
    chk({31'h0, slot_en}, 32'h1, "slot policy enabled after data lock");
    cmd(ZLAC_OP_READ4, ZLAC_ZONE_DATA, 8'h00, 1'b0);
    case (m)
      2'd1: begin
        reg_wr(`ZLAC_OFF_WDATA, VB, `ZLAC_RESP_OKAY);
        cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
        reg_wr(`ZLAC_OFF_WDATA, `ZLAC_OTP_ERASED, `ZLAC_RESP_OKAY);
        cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
        reg_rd(`ZLAC_OFF_RDATA, VA & VB, `ZLAC_RESP_OKAY);
      end
      2'd2: begin
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h00, 1'b1);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h04, 1'b1);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h08, 1'b0);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
        reg_rd(`ZLAC_OFF_RDATA, VA, `ZLAC_RESP_OKAY);
        cmd(ZLAC_OP_READ32, ZLAC_ZONE_OTP, 8'h20, 1'b1);
        cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h3c, 1'b1);
      end
      default: begin
        cmd(ZLAC_OP_WRITE, ZLAC_ZONE_OTP, 8'h0c, 1'b1);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h0c, 1'b0);
        reg_rd(`ZLAC_OFF_RDATA, VA, `ZLAC_RESP_OKAY);
        cmd(ZLAC_OP_READ4, ZLAC_ZONE_OTP, 8'h3c, 1'b0);
        reg_rd(`ZLAC_OFF_RDATA, `ZLAC_OTP_ERASED, `ZLAC_RESP_OKAY);
        cmd(ZLAC_OP_READ32, ZLAC_ZONE_OTP, 8'h00, 1'b0);
        reg_rd(`ZLAC_OFF_RDATA, `ZLAC_OTP_ERASED, `ZLAC_RESP_OKAY);
      end
    endcase
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    do_reset;
    t_reset;
    t_unlocked;
    for (int m = 0; m < 4; m++) t_mode(m[1:0]);
    give_verdict;
  end
endmodule
